//--- pkg/eqfir_pkg.sv
`default_nettype none
package eqfir_pkg;

  // Register indices; byte address is four times the index
  localparam logic [13:0] XFER_IDX   = 14'h000f;
  localparam logic [13:0] GAIN_IDX   = 14'h0df9;
  localparam logic [13:0] X_BASE_IDX = 14'h0e00;
  localparam logic [13:0] X_LAST_IDX = 14'h0e7f;
  localparam logic [13:0] Y_BASE_IDX = 14'h0f00;
  localparam logic [13:0] Y_LAST_IDX = 14'h0f7f;

  // Field positions
  localparam int unsigned XFER_BIT   = 0;
  localparam int unsigned FIRST_LSB  = 0;
  localparam int unsigned SECOND_LSB = 4;
  localparam int unsigned IDX_LSB    = 2;

  // Reset values
  localparam logic [2:0]  GAIN_RST   = 3'h0;
  localparam logic [7:0]  COEF_RST   = 8'h00;
  localparam logic [31:0] DAT_RST    = 32'h0000_0000;

  // Gain codes and the matching binary shift (6 dB per step)
  localparam logic [2:0] CODE_M12 = 3'h6;
  localparam logic [2:0] CODE_M6  = 3'h7;
  localparam logic [2:0] CODE_0   = 3'h0;
  localparam logic [2:0] CODE_P6  = 3'h1;
  localparam logic [2:0] CODE_P12 = 3'h2;
  localparam logic signed [2:0] SHIFT_M12 = 3'sh6;
  localparam logic signed [2:0] SHIFT_M6  = 3'sh7;
  localparam logic signed [2:0] SHIFT_0   = 3'sh0;
  localparam logic signed [2:0] SHIFT_P6  = 3'sh1;
  localparam logic signed [2:0] SHIFT_P12 = 3'sh2;

  typedef struct packed {
    logic [2:0]        second_filter_gain;
    logic signed [2:0] second_shift;
    logic [2:0]        first_filter_gain;
    logic signed [2:0] first_shift;
  } eqfir_gain_t;

  // Unused codes fall back to unity
  function automatic logic signed [2:0] eqfir_shift(input logic [2:0] code);
    logic signed [2:0] s;
    s = SHIFT_0;
    case (code)
      CODE_M12: s = SHIFT_M12;
      CODE_M6:  s = SHIFT_M6;
      CODE_P6:  s = SHIFT_P6;
      CODE_P12: s = SHIFT_P12;
      default:  s = SHIFT_0;
    endcase
    return s;
  endfunction : eqfir_shift

endpackage : eqfir_pkg
`default_nettype wire

//--- rtl/eqfir_coef_bank.sv
`timescale 1ns/1ps
`default_nettype none
module eqfir_coef_bank #(
  parameter int unsigned DEPTH = 128,
  parameter int unsigned WIDTH = 8
) (
  input  wire logic                             clk_sys_in,
  input  wire logic                             rst_in,
  input  wire logic                             wr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0]         wr_idx_in,
  input  wire logic [WIDTH-1:0]                 wr_data_in,
  input  wire logic                             commit_in,
  output logic      [DEPTH-1:0][WIDTH-1:0]      staged_out,
  output logic      [DEPTH-1:0][WIDTH-1:0]      active_out
);

  logic [DEPTH-1:0][WIDTH-1:0] staged;
  logic [DEPTH-1:0][WIDTH-1:0] next_staged;
  logic [DEPTH-1:0][WIDTH-1:0] active;
  logic [DEPTH-1:0][WIDTH-1:0] next_active;

  always_comb begin
    next_staged = staged;
    next_active = active;
    if (wr_en_in) begin
      next_staged[wr_idx_in] = wr_data_in;
    end
    // Whole bank moves at once; old staged values are copied
    if (commit_in) begin
      next_active = staged;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      staged <= '0;
      active <= '0;
    end else begin
      staged <= next_staged;
      active <= next_active;
    end
  end

  assign staged_out = staged;
  assign active_out = active;

endmodule : eqfir_coef_bank
`default_nettype wire

//--- rtl/eqfir_coef_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Second gain field bits 6:4 sets shift
// - First gain field bits 2:0, same encoding
// - 128 first-bank coefficient bytes, reset zero
// - 128 second-bank coefficient bytes, reset zero
// - New coefficients apply only after transfer bit
// - Gain register at 0x0DF9, bit 7 zero
module eqfir_coef_regs #(
  parameter int unsigned DEPTH = 128,
  parameter int unsigned WIDTH = 8
) (
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_in,
  input  wire logic                        wb_cyc_in,
  input  wire logic                        wb_stb_in,
  input  wire logic                        wb_we_in,
  input  wire logic [15:0]                 wb_adr_in,
  input  wire logic [3:0]                  wb_sel_in,
  input  wire logic [31:0]                 wb_dat_in,
  output logic      [31:0]                 wb_dat_out,
  output logic                             wb_ack_out,
  output eqfir_pkg::eqfir_gain_t           gain_out,
  output logic      [DEPTH-1:0][WIDTH-1:0] x_coef_out,
  output logic      [DEPTH-1:0][WIDTH-1:0] y_coef_out,
  output logic                             xfer_out
);

  localparam int unsigned IW = $clog2(DEPTH);

  logic [13:0]                 word_idx;
  logic                        gain_hit;
  logic                        xfer_hit;
  logic                        x_hit;
  logic                        y_hit;
  logic                        req;
  logic                        wr_en;
  logic                        commit;
  logic [7:0]                  rd_byte;
  logic [DEPTH-1:0][WIDTH-1:0] x_staged;
  logic [DEPTH-1:0][WIDTH-1:0] y_staged;
  logic                        ack;
  logic                        next_ack;
  logic [31:0]                 dat;
  logic [31:0]                 next_dat;
  eqfir_pkg::eqfir_gain_t      gain;
  eqfir_pkg::eqfir_gain_t      next_gain;

  // Address decode
  always_comb begin
    word_idx = wb_adr_in[15:eqfir_pkg::IDX_LSB];
    gain_hit = 1'b0;
    xfer_hit = 1'b0;
    x_hit    = 1'b0;
    y_hit    = 1'b0;
    if (word_idx == eqfir_pkg::GAIN_IDX) begin
      gain_hit = 1'b1;
    end else if (word_idx == eqfir_pkg::XFER_IDX) begin
      xfer_hit = 1'b1;
    end else if (word_idx >= eqfir_pkg::X_BASE_IDX && word_idx <= eqfir_pkg::X_LAST_IDX) begin
      x_hit = 1'b1;
    end else if (word_idx >= eqfir_pkg::Y_BASE_IDX && word_idx <= eqfir_pkg::Y_LAST_IDX) begin
      y_hit = 1'b1;
    end
  end

  // Writes land on the edge where ack is high
  assign req    = wb_cyc_in && wb_stb_in && !ack;
  assign wr_en  = wb_cyc_in && wb_stb_in && wb_we_in && ack && wb_sel_in[0];
  assign commit = wr_en && xfer_hit && wb_dat_in[eqfir_pkg::XFER_BIT];

  eqfir_coef_bank #(
    .DEPTH(DEPTH),
    .WIDTH(WIDTH)
  ) u_x_bank (
    .clk_sys_in(clk_sys_in),
    .rst_in    (rst_in),
    .wr_en_in  (wr_en && x_hit),
    .wr_idx_in (word_idx[IW-1:0]),
    .wr_data_in(wb_dat_in[WIDTH-1:0]),
    .commit_in (commit),
    .staged_out(x_staged),
    .active_out(x_coef_out)
  );

  eqfir_coef_bank #(
    .DEPTH(DEPTH),
    .WIDTH(WIDTH)
  ) u_y_bank (
    .clk_sys_in(clk_sys_in),
    .rst_in    (rst_in),
    .wr_en_in  (wr_en && y_hit),
    .wr_idx_in (word_idx[IW-1:0]),
    .wr_data_in(wb_dat_in[WIDTH-1:0]),
    .commit_in (commit),
    .staged_out(y_staged),
    .active_out(y_coef_out)
  );

  // Read mux; reserved bits and transfer bit read zero
  always_comb begin
    rd_byte = 8'h00;
    if (gain_hit) begin
      rd_byte = {1'b0, gain.second_filter_gain, 1'b0, gain.first_filter_gain};
    end else if (x_hit) begin
      rd_byte = 8'(x_staged[word_idx[IW-1:0]]);
    end else if (y_hit) begin
      rd_byte = 8'(y_staged[word_idx[IW-1:0]]);
    end
  end

  // Bus answer group
  always_comb begin
    next_ack = req;
    next_dat = eqfir_pkg::DAT_RST;
    if (req && !wb_we_in) begin
      next_dat = {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ack <= 1'b0;
      dat <= eqfir_pkg::DAT_RST;
    end else begin
      ack <= next_ack;
      dat <= next_dat;
    end
  end

  // Gain group; takes effect directly, not staged
  always_comb begin
    next_gain = gain;
    if (wr_en && gain_hit) begin
      next_gain.second_filter_gain = wb_dat_in[eqfir_pkg::SECOND_LSB +: 3];
      next_gain.first_filter_gain  = wb_dat_in[eqfir_pkg::FIRST_LSB +: 3];
    end
    next_gain.second_shift = eqfir_pkg::eqfir_shift(next_gain.second_filter_gain);
    next_gain.first_shift  = eqfir_pkg::eqfir_shift(next_gain.first_filter_gain);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      gain <= '{second_filter_gain: eqfir_pkg::GAIN_RST, second_shift: eqfir_pkg::SHIFT_0,
                first_filter_gain: eqfir_pkg::GAIN_RST, first_shift: eqfir_pkg::SHIFT_0};
    end else begin
      gain <= next_gain;
    end
  end

  assign wb_ack_out = ack;
  assign wb_dat_out = dat;
  assign gain_out   = gain;
  assign xfer_out   = commit;

  a_ack_single_cycle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");

  a_second_gain_shift: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ((gain_out.second_filter_gain == eqfir_pkg::CODE_M12)
      |-> (gain_out.second_shift == eqfir_pkg::SHIFT_M12))
    and ((gain_out.second_filter_gain == eqfir_pkg::CODE_P12)
      |-> (gain_out.second_shift == eqfir_pkg::SHIFT_P12)))
    else $error("second gain shift does not match code");

  a_first_gain_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (wr_en && gain_hit) |=> (gain_out.first_filter_gain == $past(wb_dat_in[2:0])
      && gain_out.first_shift == eqfir_pkg::eqfir_shift($past(wb_dat_in[2:0]))))
    else $error("first gain not updated from write");

  a_x_read_data: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (req && !wb_we_in && x_hit) |=> (wb_ack_out
      && wb_dat_out == {24'h00_0000, 8'($past(x_staged[word_idx[IW-1:0]]))}))
    else $error("first bank read data wrong");

  a_y_read_data: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (req && !wb_we_in && y_hit) |=> (wb_ack_out
      && wb_dat_out == {24'h00_0000, 8'($past(y_staged[word_idx[IW-1:0]]))}))
    else $error("second bank read data wrong");

  a_active_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !$past(commit) |-> ($stable(x_coef_out) && $stable(y_coef_out)))
    else $error("active coefficients changed without transfer");

  a_gain_readback: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (req && !wb_we_in && gain_hit) |=> (wb_dat_out[7] == 1'b0 && wb_dat_out[3] == 1'b0
      && wb_dat_out[6:4] == gain_out.second_filter_gain))
    else $error("gain readback wrong");

  a_commit_copy: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    commit |=> (x_coef_out == $past(x_staged) && y_coef_out == $past(y_staged)))
    else $error("transfer did not copy staged banks");

endmodule : eqfir_coef_regs
`default_nettype wire

//--- verif/eqfir_coef_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module eqfir_coef_regs_bench;
  logic                   clk_sys_in;
  logic                   rst_in;
  logic                   wb_cyc;
  logic                   wb_stb;
  logic                   wb_we;
  logic [15:0]            wb_adr;
  logic [3:0]             wb_sel;
  logic [31:0]            wb_wdat;
  logic [31:0]            wb_rdat;
  logic                   wb_ack;
  logic                   xfer;
  logic                   last_xfer;
  logic [31:0]            rd;
  eqfir_pkg::eqfir_gain_t gain;
  logic [127:0][7:0]      x_coef;
  logic [127:0][7:0]      y_coef;
  int                     fails;
  int                     num_checks;
  int                     cycles;

  eqfir_coef_regs #(.DEPTH(128), .WIDTH(8)) uut (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .wb_cyc_in  (wb_cyc),
    .wb_stb_in  (wb_stb),
    .wb_we_in   (wb_we),
    .wb_adr_in  (wb_adr),
    .wb_sel_in  (wb_sel),
    .wb_dat_in  (wb_wdat),
    .wb_dat_out (wb_rdat),
    .wb_ack_out (wb_ack),
    .gain_out   (gain),
    .x_coef_out (x_coef),
    .y_coef_out (y_coef),
    .xfer_out   (xfer)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One classic cycle; ack and read data taken at the rising edge
  task automatic wb(input logic we, input logic [13:0] idx, input logic [31:0] wd,
                    input logic [3:0] sel, output logic [31:0] rdat);
    @(posedge clk_sys_in);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= {idx, 2'b00};
    wb_sel  <= sel;
    wb_wdat <= wd;
    do begin
      @(posedge clk_sys_in);
    end while (wb_ack !== 1'b1);
    rdat = wb_rdat;
    last_xfer = xfer;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    logic [31:0] dummy;
    wb(1'b1, idx, {24'h000000, d}, 4'hf, dummy);
  endtask : wr

  task automatic rdchk(input logic [13:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    wb(1'b0, idx, 32'h0000_0000, 4'hf, r);
    chk(r, {24'h000000, exp});
  endtask : rdchk

  // Expected shift: codes 110,111,000,001,010 are -2..+2; others unity
  function automatic logic [2:0] sh(input logic [2:0] c);
    return (c == 3'h3 || c == 3'h4 || c == 3'h5) ? 3'h0 : c;
  endfunction : sh

  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    rst_in = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 16'h0000;
    wb_sel = 4'h0;
    wb_wdat = 32'h0000_0000;
    fails = 0;
    num_checks = 0;
    cycles = 0;
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    chk({20'h00000, gain}, 32'h0000_0000);
    rdchk(eqfir_pkg::GAIN_IDX, 8'h00);
    rdchk(eqfir_pkg::X_BASE_IDX, 8'h00);
    rdchk(eqfir_pkg::Y_LAST_IDX, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(eqfir_pkg::GAIN_IDX, {1'b1, 3'(i), 1'b1, ~3'(i)});
      rdchk(eqfir_pkg::GAIN_IDX, {1'b0, 3'(i), 1'b0, ~3'(i)});
      chk({29'h0, gain.second_filter_gain}, {29'h0, 3'(i)});
      chk({29'h0, gain.second_shift}, {29'h0, sh(3'(i))});
      chk({29'h0, gain.first_filter_gain}, {29'h0, ~3'(i)});
      chk({29'h0, gain.first_shift}, {29'h0, sh(~3'(i))});
    end
    wr(eqfir_pkg::X_BASE_IDX, 8'ha5);
    wr(eqfir_pkg::X_LAST_IDX, 8'h5a);
    wr(eqfir_pkg::Y_BASE_IDX, 8'h3c);
    wr(eqfir_pkg::Y_LAST_IDX, 8'hc3);
    wb(1'b1, eqfir_pkg::X_BASE_IDX + 14'h0001, 32'h0000_00ff, 4'he, rd);
    rdchk(eqfir_pkg::X_BASE_IDX + 14'h0001, 8'h00);
    wr(eqfir_pkg::X_LAST_IDX + 14'h0001, 8'hff);
    rdchk(eqfir_pkg::X_LAST_IDX + 14'h0001, 8'h00);
    rdchk(eqfir_pkg::X_BASE_IDX, 8'ha5);
    rdchk(eqfir_pkg::X_LAST_IDX, 8'h5a);
    rdchk(eqfir_pkg::Y_BASE_IDX, 8'h3c);
    rdchk(eqfir_pkg::Y_LAST_IDX, 8'hc3);
    chk(x_coef[0], 8'h00);
    chk(y_coef[127], 8'h00);
    chk(last_xfer, 1'b0);
    wr(eqfir_pkg::XFER_IDX, 8'h01);
    chk(last_xfer, 1'b1);
    rdchk(eqfir_pkg::XFER_IDX, 8'h00);
    chk(x_coef[0], 8'ha5);
    chk(x_coef[127], 8'h5a);
    chk(y_coef[0], 8'h3c);
    chk(y_coef[127], 8'hc3);
    wr(eqfir_pkg::X_BASE_IDX, 8'h11);
    rdchk(eqfir_pkg::X_BASE_IDX, 8'h11);
    chk(x_coef[0], 8'ha5);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    chk(x_coef[127], 8'h00);
    chk(y_coef[0], 8'h00);
    chk({20'h00000, gain}, 32'h0000_0000);
    rdchk(eqfir_pkg::Y_BASE_IDX, 8'h00);
    end_of_test();
  end
endmodule : eqfir_coef_regs_bench
`default_nettype wire
